// ---- rtl/tic_pkg.sv ----
// Constants, register map and encodings of the main timer with input capture
// Overview of operation
// - Prescaler divides clock by 1, 4, 8, 16
// - Count from zero, wrap, set overflow flag
// - Software cannot load, reset or stop counter
// - Three capture, four compare, one shared channel
// - Each function has own enable and vector
// - Low port lines readable at all times
// - Compare-owned lines ignore software port writes
// - First compare drives any upper line combination
// - Synchronised captures latch a stable count
// - Shared channel compares out of reset
// - Own writes on output line3 cause captures
// - Shared register ignores writes while capturing
// - Edge pair: off, rising, falling, any
// - Four edge pairs reset; fourth needs select
// - Channels independent; same period, same value
// - Capture moves full count in parallel
// - Dedicated captures unreset, read as byte registers
// - High-byte read blocks capture one cycle
// - Blocked capture delayed one cycle, kept
package tic_pkg;

  localparam int CNT_W = 16;
  localparam int NCAP = 4;
  localparam int NCMP = 5;
  localparam int ADDR_W = 8;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] OFS_PACC_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_EDGE_CTRL = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CMP_ACT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_MASK_ONE = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_FLAG_ONE = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_MASK_TWO = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_FLAG_TWO = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_PORT_A = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_OC1_MASK = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_OC1_DATA = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_PAIR_BASE = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_CMP_BASE = 8'h60;

  // Field positions in pulse_accum_control; POS_OVF is the overflow bit of the second mask and flag
  localparam int POS_PRESCALE = 0;
  localparam int POS_CH4_SEL = 2;
  localparam int POS_LINE3_DIR = 3;
  localparam int POS_LINE7_DIR = 4;
  localparam int POS_OVF = 7;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [CNT_W-1:0] RST_COUNT = 16'h0000;
  localparam logic [CNT_W-1:0] RST_CMP = 16'hFFFF;

  // Prescale terminal counts, divide by 1, 4, 8, 16
  localparam logic [3:0] PRE_TC0 = 4'h0;
  localparam logic [3:0] PRE_TC1 = 4'h3;
  localparam logic [3:0] PRE_TC2 = 4'h7;
  localparam logic [3:0] PRE_TC3 = 4'hF;

  typedef enum logic [1:0] {
    TIC_ACT_NONE = 2'h0,
    TIC_ACT_TOGGLE = 2'h1,
    TIC_ACT_CLEAR = 2'h2,
    TIC_ACT_SET = 2'h3
  } tic_act_e;

endpackage : tic_pkg

// ---- rtl/tic_timer.sv ----
// Main timer: prescaled free-running counter, input capture, output compare, APB
//
// The APB slave port and the register offsets were chosen for this implementation.
module tic_timer import tic_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Port A lines
  input wire logic [7:0] pa_in,
  output logic [7:0] pa_out,
  output logic [7:0] pa_oe,
  // Interrupt requests, one per timer function
  output logic [8:0] irq_vec
);

  logic [7:0] pacc_ctrl_ff;
  logic [7:0] edge_ctrl_ff;
  logic [7:0] cmp_act_ff;
  logic [7:0] mask_one_ff;
  logic [7:0] flag_one_ff;
  logic mask_ovf_ff;
  logic flag_ovf_ff;
  logic [7:3] oc1_mask_ff;
  logic [7:3] oc1_data_ff;
  logic [7:0] pa_data_ff;
  logic [3:0] pre_cnt_ff;
  logic [CNT_W-1:0] count_ff;
  logic cnt_new_ff;
  logic [CNT_W-1:0] oc_ff [4];
  logic [CNT_W-1:0] shared_ff;
  logic [CNT_W-1:0] cap_ff [3];
  logic [7:0] sync1_ff;
  logic [7:0] sync2_ff;
  logic [NCAP-1:0] prev_ff;
  logic [NCAP-1:0] hold_ff;
  logic [NCAP-1:0] pend_ff;
  logic [CNT_W-1:0] pend_val_ff [NCAP];
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic [7:0] pa_out_ff;
  logic [7:0] pa_oe_ff;
  logic [8:0] irq_ff;

  logic [1:0] prescale;
  logic ch4_sel;
  logic line3_dir;
  logic line7_dir;
  logic tick;
  logic [3:0] pre_tc;
  logic acc_done;
  logic wr_en;
  logic rd_en;
  logic [NCAP-1:0] cap_done;
  logic [CNT_W-1:0] cap_val [NCAP];
  logic [NCAP-1:0] rd_hi;
  logic [NCMP-1:0] match;
  logic [7:0] flag_set;
  logic [7:3] cmp_owned;
  logic [31:0] rd_data;
  logic rd_bad;

  assign prescale = pacc_ctrl_ff[POS_PRESCALE +: 2];
  assign ch4_sel = pacc_ctrl_ff[POS_CH4_SEL];
  assign line3_dir = pacc_ctrl_ff[POS_LINE3_DIR];
  assign line7_dir = pacc_ctrl_ff[POS_LINE7_DIR];

  // Access completes on the edge where pready is seen high
  assign acc_done = psel & penable & pready_ff;
  assign wr_en = acc_done & pwrite;
  assign rd_en = acc_done & ~pwrite;

  always_comb begin
    case (prescale)
      2'h0: pre_tc = PRE_TC0;
      2'h1: pre_tc = PRE_TC1;
      2'h2: pre_tc = PRE_TC2;
      default: pre_tc = PRE_TC3;
    endcase
  end

  assign tick = (pre_cnt_ff >= pre_tc);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt_ff <= 4'h0;
    end else if (tick) begin
      pre_cnt_ff <= 4'h0;
    end else begin
      pre_cnt_ff <= pre_cnt_ff + 4'h1;
    end
  end

  // No bus path reaches the counter: it only counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_ff <= RST_COUNT;
      cnt_new_ff <= 1'b0;
    end else begin
      cnt_new_ff <= tick;
      if (tick) begin
        count_ff <= count_ff + 16'h0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= 8'h00;
      sync2_ff <= 8'h00;
    end else begin
      sync1_ff <= pa_in;
      sync2_ff <= sync1_ff;
    end
  end

  // Channel 0..2 watch lines 2..0, channel 3 is the shared line 3
  for (genvar g = 0; g < NCAP; g++) begin : g_cap
    localparam int LINE = (g == 3) ? 3 : 2 - g;
    localparam int EB = (g == 3) ? 6 : 4 - 2 * g;
    localparam logic [ADDR_W-1:0] HI_ADDR = ADDR_W'(OFS_PAIR_BASE + 8 * g);
    logic lvl;
    logic rise;
    logic fall;
    logic en;
    logic hit;

    // With line 3 driven, our own port writes make the capture edges
    assign lvl = (g == 3 && line3_dir) ? pa_data_ff[3] : sync2_ff[LINE];
    assign rise = lvl & ~prev_ff[g];
    assign fall = ~lvl & prev_ff[g];
    assign en = (g == 3) ? ch4_sel : 1'b1;
    assign hit = en & ((edge_ctrl_ff[EB] & rise) | (edge_ctrl_ff[EB+1] & fall));
    assign rd_hi[g] = rd_en & (paddr == HI_ADDR);
    assign cap_done[g] = ~hold_ff[g] & (hit | pend_ff[g]);
    // Old count is sampled on the edge that may bump it, so the value is settled
    assign cap_val[g] = hit ? count_ff : pend_val_ff[g];

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        prev_ff[g] <= 1'b0;
        hold_ff[g] <= 1'b0;
        pend_ff[g] <= 1'b0;
        pend_val_ff[g] <= RST_COUNT;
      end else begin
        prev_ff[g] <= lvl;
        hold_ff[g] <= rd_hi[g];
        pend_ff[g] <= hold_ff[g] & (hit | pend_ff[g]);
        if (hit && hold_ff[g]) begin
          pend_val_ff[g] <= count_ff;
        end
      end
    end
  end

  // Dedicated capture latches keep their contents through reset
  always_ff @(posedge pclk) begin
    for (int i = 0; i < 3; i++) begin
      if (cap_done[i]) begin
        cap_ff[i] <= cap_val[i];
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      match[i] = cnt_new_ff & (count_ff == oc_ff[i]);
    end
    match[4] = cnt_new_ff & ~ch4_sel & (count_ff == shared_ff);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) begin
        oc_ff[i] <= RST_CMP;
      end
    end else if (wr_en) begin
      for (int i = 0; i < 4; i++) begin
        if (paddr == ADDR_W'(OFS_CMP_BASE + 4 * i)) begin
          oc_ff[i] <= pwdata[CNT_W-1:0];
        end
      end
    end
  end

  // Shared register: compare value out of reset, capture latch when selected
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shared_ff <= RST_CMP;
    end else if (ch4_sel) begin
      if (cap_done[3]) begin
        shared_ff <= cap_val[3];
      end
    end else if (wr_en && paddr == ADDR_W'(OFS_PAIR_BASE + 8'h18)) begin
      shared_ff[15:8] <= pwdata[7:0];
    end else if (wr_en && paddr == ADDR_W'(OFS_PAIR_BASE + 8'h1C)) begin
      shared_ff[7:0] <= pwdata[7:0];
    end
  end

  // A line is compare-owned when an action or the first compare's mask claims it, line 3 only while ch4_sel is clear
  always_comb begin
    cmp_owned[7] = oc1_mask_ff[7];
    cmp_owned[6] = oc1_mask_ff[6] | (cmp_act_ff[7:6] != TIC_ACT_NONE);
    cmp_owned[5] = oc1_mask_ff[5] | (cmp_act_ff[5:4] != TIC_ACT_NONE);
    cmp_owned[4] = oc1_mask_ff[4] | (cmp_act_ff[3:2] != TIC_ACT_NONE);
    cmp_owned[3] = ~ch4_sel & (oc1_mask_ff[3] | (cmp_act_ff[1:0] != TIC_ACT_NONE));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pa_data_ff <= RST_BYTE;
    end else begin
      if (wr_en && paddr == OFS_PORT_A) begin
        for (int b = 3; b < 8; b++) begin
          if (!cmp_owned[b]) begin
            pa_data_ff[b] <= pwdata[b];
          end
        end
      end
      // Compares 2..5 drive lines 6..3, each by its action pair
      for (int k = 1; k < NCMP; k++) begin
        if (match[k]) begin
          case (tic_act_e'(cmp_act_ff[2*(4-k) +: 2]))
            TIC_ACT_TOGGLE: pa_data_ff[7-k] <= ~pa_data_ff[7-k];
            TIC_ACT_CLEAR: pa_data_ff[7-k] <= 1'b0;
            TIC_ACT_SET: pa_data_ff[7-k] <= 1'b1;
            default: pa_data_ff[7-k] <= pa_data_ff[7-k];
          endcase
        end
      end
      // First compare wins over the single-line compares on shared lines
      if (match[0]) begin
        for (int b = 3; b < 8; b++) begin
          if (oc1_mask_ff[b]) begin
            pa_data_ff[b] <= oc1_data_ff[b];
          end
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pa_out_ff <= 8'h00;
      pa_oe_ff <= 8'h00;
    end else begin
      pa_out_ff <= {pa_data_ff[7:3], 3'b000};
      pa_oe_ff <= {line7_dir | oc1_mask_ff[7], 3'b111, line3_dir, 3'b000};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pacc_ctrl_ff <= RST_BYTE;
      edge_ctrl_ff <= RST_BYTE;
      cmp_act_ff <= RST_BYTE;
      mask_one_ff <= RST_BYTE;
      mask_ovf_ff <= 1'b0;
      oc1_mask_ff <= 5'h00;
      oc1_data_ff <= 5'h00;
    end else if (wr_en) begin
      if (paddr == OFS_PACC_CTRL) begin
        pacc_ctrl_ff <= {3'b000, pwdata[4:0]};
      end else if (paddr == OFS_EDGE_CTRL) begin
        edge_ctrl_ff <= pwdata[7:0];
      end else if (paddr == OFS_CMP_ACT) begin
        cmp_act_ff <= pwdata[7:0];
      end else if (paddr == OFS_MASK_ONE) begin
        mask_one_ff <= pwdata[7:0];
      end else if (paddr == OFS_MASK_TWO) begin
        mask_ovf_ff <= pwdata[POS_OVF];
      end else if (paddr == OFS_OC1_MASK) begin
        oc1_mask_ff <= pwdata[7:3];
      end else if (paddr == OFS_OC1_DATA) begin
        oc1_data_ff <= pwdata[7:3];
      end
    end
  end

  // Flag layout: 7..4 compares 1..4, 3 shared channel, 2..0 captures 1..3
  always_comb begin
    flag_set = {match[0], match[1], match[2], match[3], 4'h0};
    flag_set[3] = match[4] | cap_done[3];
    flag_set[2] = cap_done[0];
    flag_set[1] = cap_done[1];
    flag_set[0] = cap_done[2];
  end

  // Write one to clear; a set in the same cycle wins so no event is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_one_ff <= RST_BYTE;
      flag_ovf_ff <= 1'b0;
    end else begin
      if (wr_en && paddr == OFS_FLAG_ONE) begin
        flag_one_ff <= (flag_one_ff & ~pwdata[7:0]) | flag_set;
      end else begin
        flag_one_ff <= flag_one_ff | flag_set;
      end
      if (tick && count_ff == 16'hFFFF) begin
        flag_ovf_ff <= 1'b1;
      end else if (wr_en && paddr == OFS_FLAG_TWO && pwdata[POS_OVF]) begin
        flag_ovf_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ff <= 9'h000;
    end else begin
      irq_ff <= {flag_ovf_ff & mask_ovf_ff, flag_one_ff & mask_one_ff};
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_bad = 1'b0;
    if (paddr == OFS_PACC_CTRL) begin
      rd_data[7:0] = pacc_ctrl_ff;
    end else if (paddr == OFS_EDGE_CTRL) begin
      rd_data[7:0] = edge_ctrl_ff;
    end else if (paddr == OFS_CMP_ACT) begin
      rd_data[7:0] = cmp_act_ff;
    end else if (paddr == OFS_MASK_ONE) begin
      rd_data[7:0] = mask_one_ff;
    end else if (paddr == OFS_FLAG_ONE) begin
      rd_data[7:0] = flag_one_ff;
    end else if (paddr == OFS_MASK_TWO) begin
      rd_data[POS_OVF] = mask_ovf_ff;
    end else if (paddr == OFS_FLAG_TWO) begin
      rd_data[POS_OVF] = flag_ovf_ff;
    end else if (paddr == OFS_PORT_A) begin
      // Low lines always show the pin, even while capturing
      rd_data[7:0] = {pa_data_ff[7:3] & {line7_dir, 3'b111, line3_dir} |
                      sync2_ff[7:3] & ~{line7_dir, 3'b111, line3_dir}, sync2_ff[2:0]};
    end else if (paddr == OFS_OC1_MASK) begin
      rd_data[7:3] = oc1_mask_ff;
    end else if (paddr == OFS_OC1_DATA) begin
      rd_data[7:3] = oc1_data_ff;
    end else if (paddr == OFS_COUNT) begin
      rd_data[CNT_W-1:0] = count_ff;
    end else if (paddr == OFS_PAIR_BASE) begin
      rd_data[7:0] = cap_ff[0][15:8];
    end else if (paddr == ADDR_W'(OFS_PAIR_BASE + 8'h04)) begin
      rd_data[7:0] = cap_ff[0][7:0];
    end else if (paddr == ADDR_W'(OFS_PAIR_BASE + 8'h08)) begin
      rd_data[7:0] = cap_ff[1][15:8];
    end else if (paddr == ADDR_W'(OFS_PAIR_BASE + 8'h0C)) begin
      rd_data[7:0] = cap_ff[1][7:0];
    end else if (paddr == ADDR_W'(OFS_PAIR_BASE + 8'h10)) begin
      rd_data[7:0] = cap_ff[2][15:8];
    end else if (paddr == ADDR_W'(OFS_PAIR_BASE + 8'h14)) begin
      rd_data[7:0] = cap_ff[2][7:0];
    end else if (paddr == ADDR_W'(OFS_PAIR_BASE + 8'h18)) begin
      rd_data[7:0] = shared_ff[15:8];
    end else if (paddr == ADDR_W'(OFS_PAIR_BASE + 8'h1C)) begin
      rd_data[7:0] = shared_ff[7:0];
    end else if (paddr == OFS_CMP_BASE) begin
      rd_data[CNT_W-1:0] = oc_ff[0];
    end else if (paddr == ADDR_W'(OFS_CMP_BASE + 8'h04)) begin
      rd_data[CNT_W-1:0] = oc_ff[1];
    end else if (paddr == ADDR_W'(OFS_CMP_BASE + 8'h08)) begin
      rd_data[CNT_W-1:0] = oc_ff[2];
    end else if (paddr == ADDR_W'(OFS_CMP_BASE + 8'h0C)) begin
      rd_data[CNT_W-1:0] = oc_ff[3];
    end else begin
      rd_bad = 1'b1;
    end
  end

  // One wait state: data and status are registered on the edge where pready rises
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else if (psel && penable && !pready_ff) begin
      pready_ff <= 1'b1;
      pslverr_ff <= rd_bad;
      prdata_ff <= pwrite ? 32'h0000_0000 : rd_data;
    end else begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign pa_out = pa_out_ff;
  assign pa_oe = pa_oe_ff;
  assign irq_vec = irq_ff;

endmodule : tic_timer

// ---- sim/tic_timer_sva.sv ----
// Assertion checker on the timer top-level ports
module tic_timer_sva import tic_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and requests
  input wire logic [7:0] pa_in,
  input wire logic [7:0] pa_out,
  input wire logic [7:0] pa_oe,
  input wire logic [8:0] irq_vec
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pin0_ff;
  logic [3:0] since_pin_ff;
  logic [3:0] since_wr_ff;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Saturating ages: the sync latency is bounded, not pinned to one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin0_ff <= 1'b0;
      since_pin_ff <= 4'hF;
    end else begin
      pin0_ff <= pa_in[0];
      since_pin_ff <= (pa_in[0] != pin0_ff) ? 4'h0 : since_pin_ff + {3'h0, since_pin_ff != 4'hF};
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_wr_ff <= 4'hF;
    end else begin
      since_wr_ff <= (psel && penable && pready && pwrite) ? 4'h0 : since_wr_ff + {3'h0, since_wr_ff != 4'hF};
    end
  end
  property p_ready_wait;
    psel && penable && !$past(penable) |=> pready;
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("pready late");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");
  property p_ready_cause;
    pready |-> psel && penable;
  endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("pready without access");
  property p_err_zero;
    pslverr && !pwrite |-> pready && prdata == 32'h0;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("error read not zero");
  property p_low_lines;
    pa_oe[2:0] == 3'h0 && pa_out[2:0] == 3'h0;
  endproperty
  a_low_lines: assert property (p_low_lines) else $error("low lines driven");
  property p_cmp_lines;
    $past(presetn) |-> pa_oe[6:4] == 3'h7;
  endproperty
  a_cmp_lines: assert property (p_cmp_lines) else $error("compare lines not driven");
  property p_line3_rst;
    !$past(presetn) |-> !pa_oe[3];
  endproperty
  a_line3_rst: assert property (p_line3_rst) else $error("line3 output after reset");
  property p_irq_rst;
    !$past(presetn) |-> irq_vec == 9'h000;
  endproperty
  a_irq_rst: assert property (p_irq_rst) else $error("request after reset");
  property p_irq_cause;
    $rose(irq_vec[0]) |-> since_pin_ff < 4'hA || since_wr_ff < 4'h4;
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("capture request without edge");
  c_cap_irq: cover property ($rose(irq_vec[0]));
  c_err: cover property (pslverr);
  c_ovf_irq: cover property ($rose(irq_vec[8]));
endmodule : tic_timer_sva

bind tic_timer tic_timer_sva i_tic_timer_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe), .irq_vec(irq_vec));

// ---- sim/tic_edge_src.sv ----
// External event source on the port A lines
module tic_edge_src (
  // Clock
  input wire logic pclk,
  // Block pin drivers
  input wire logic [7:0] pa_out,
  input wire logic [7:0] pa_oe,
  // Resolved pin levels
  output logic [7:0] pa_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ext_ff = 8'h00;
  // A driven line shows the block's own level, so own writes reach the edge logic
  assign pa_in = (pa_oe & pa_out) | (~pa_oe & ext_ff);
  task drive(input logic [7:0] v);
    ext_ff <= v;
  endtask : drive
  task drive_after(input int n, input logic [7:0] v);
    repeat (n) @(posedge pclk);
    ext_ff <= v;
  endtask : drive_after
endmodule : tic_edge_src

// ---- sim/testbench.sv ----
// Self-checking bench for the timer: APB master, pin events, queued read checks
module testbench import tic_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [31:0] exp;
    logic [31:0] msk;
    logic [7:0] adr;
  } tic_exp_s;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] pa_in;
  logic [7:0] pa_out;
  logic [7:0] pa_oe;
  logic [8:0] irq_vec;
  logic last_err;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;
  int dv[4] = '{1, 4, 8, 16};
  tic_exp_s exp_q[$];
  tic_exp_s e_m;
  tic_timer i_tic_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe), .irq_vec(irq_vec));
  tic_edge_src i_tic_edge_src (.pclk(pclk), .pa_out(pa_out), .pa_oe(pa_oe), .pa_in(pa_in));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) cyc <= presetn ? cyc + 1 : 0;
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task complete_run();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run
  task apb(input logic wr, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rdat);
    int g;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= adr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    g = 0;
    do begin
      @(posedge pclk);
      g++;
    end while (pready !== 1'b1 && g < 20);
    if (g >= 20) begin
      check("pready", 0, 1);
      complete_run();
    end
    rdat = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] adr, input logic [31:0] wd);
    logic [31:0] x;
    apb(1'b1, adr, wd, x);
  endtask : wr
  task rd(input logic [7:0] adr, input logic [31:0] exp, input logic [31:0] msk, output logic [31:0] d);
    exp_q.push_back('{exp, msk, adr});
    apb(1'b0, adr, 32'h0, d);
  endtask : rd
  task rd16(input int c, output logic [15:0] v);
    logic [31:0] h;
    logic [31:0] l;
    rd(OFS_PAIR_BASE + 8'(8 * c), 0, 0, h);
    rd(OFS_PAIR_BASE + 8'(8 * c + 4), 0, 0, l);
    v = {h[7:0], l[7:0]};
  endtask : rd16
  // Read results are matched against the oldest note in order of completion
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0 && exp_q.size() > 0) begin
      e_m = exp_q.pop_front();
      if (e_m.msk != 0) check($sformatf("reg_%h", e_m.adr), prdata & e_m.msk, e_m.exp & e_m.msk);
    end
  end
  initial begin
    repeat (90000) @(posedge pclk);
    check("watchdog", 0, 1);
    complete_run();
  end
  initial begin
    logic [31:0] d;
    logic [15:0] a;
    logic [15:0] b;
    int v;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    presetn = 1'b0;
    void'($urandom(32'hA45A3BFB));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_EDGE_CTRL, 0, 32'hFF, d);
    rd(OFS_PACC_CTRL, 0, 32'hFF, d);
    check("line3_oe", pa_oe[3], 0);
    rd(8'hFC, 0, 32'hFFFFFFFF, d);
    check("slverr", last_err, 1);
    wr(OFS_MASK_ONE, 32'h05);
    for (int c = 0; c < 3; c++) begin
      for (int m = 0; m < 4; m++) begin
        wr(OFS_EDGE_CTRL, m << (4 - 2 * c));
        for (int e = 0; e < 2; e++) begin
          @(posedge pclk);
          i_tic_edge_src.drive(e == 0 ? 8'h01 << (2 - c) : 8'h00);
          repeat (8) @(posedge pclk);
          check("irq", irq_vec[2 - c], (m >> e) & 1 & (c != 1));
          rd(OFS_FLAG_ONE, ((m >> e) & 1) << (2 - c), 1 << (2 - c), d);
          wr(OFS_FLAG_ONE, 32'hFF);
        end
      end
    end
    wr(OFS_EDGE_CTRL, 32'h00);
    repeat (4) begin
      v = $urandom;
      @(posedge pclk);
      i_tic_edge_src.drive(8'(v & 7));
      repeat (4) @(posedge pclk);
      rd(OFS_PORT_A, v, 32'h07, d);
    end
    @(posedge pclk);
    i_tic_edge_src.drive(8'h00);
    wr(OFS_EDGE_CTRL, 32'h14);
    wr(OFS_FLAG_ONE, 32'hFF);
    // Both edges fall in the cycle after the high-byte read of the first pair
    fork
      rd(OFS_PAIR_BASE, 0, 0, d);
      i_tic_edge_src.drive_after(2, 8'h06);
    join
    repeat (8) @(posedge pclk);
    rd(OFS_FLAG_ONE, 32'h06, 32'h06, d);
    rd16(0, a);
    rd16(1, b);
    check("same_count", a, b);
    for (int ps = 0; ps < 4; ps++) begin
      @(posedge pclk);
      i_tic_edge_src.drive(8'h00);
      wr(OFS_PACC_CTRL, ps);
      repeat (20) @(posedge pclk);
      i_tic_edge_src.drive(8'h04);
      i_tic_edge_src.drive_after(64, 8'h06);
      repeat (8) @(posedge pclk);
      rd16(0, a);
      rd16(1, b);
      check("span", 16'(b - a), 64 / dv[ps]);
    end
    wr(OFS_PACC_CTRL, 32'h00);
    rd16(0, a);
    wr(OFS_PAIR_BASE, {24'h0, ~a[15:8]});
    rd(OFS_PAIR_BASE, a[15:8], 32'hFF, d);
    wr(OFS_PACC_CTRL, 32'h04);
    wr(OFS_PAIR_BASE + 8'h18, 32'h00);
    rd(OFS_PAIR_BASE + 8'h18, 32'hFF, 32'hFF, d);
    rd(OFS_PAIR_BASE + 8'h1C, 32'hFF, 32'hFF, d);
    wr(OFS_PACC_CTRL, 32'h00);
    // Compare 1 owns line 7, compare 5 sets line 3 from the shared register
    wr(OFS_OC1_MASK, 32'h80);
    wr(OFS_OC1_DATA, 32'h80);
    wr(OFS_CMP_ACT, 32'h03);
    wr(OFS_PORT_A, 32'h80);
    rd(OFS_COUNT, 0, 0, d);
    a = d[15:0] + 16'h0100;
    wr(OFS_CMP_BASE, {16'h0, a});
    wr(OFS_PAIR_BASE + 8'h18, {24'h0, a[15:8]});
    wr(OFS_PAIR_BASE + 8'h1C, {24'h0, a[7:0]});
    wr(OFS_FLAG_ONE, 32'hFF);
    @(posedge pclk);
    check("oc1_line_held", pa_out[7], 0);
    repeat (300) @(posedge pclk);
    check("oc1_line", pa_out[7], 1);
    check("oc5_line", pa_out[3], 1);
    rd(OFS_FLAG_ONE, 32'h88, 32'hFF, d);
    // Own writes on a driven line 3 are edges, but only once the fourth pair is selected
    wr(OFS_CMP_ACT, 32'h00);
    wr(OFS_EDGE_CTRL, 32'hC0);
    wr(OFS_PACC_CTRL, 32'h08);
    wr(OFS_FLAG_ONE, 32'hFF);
    wr(OFS_PORT_A, 32'h00);
    repeat (4) @(posedge pclk);
    rd(OFS_FLAG_ONE, 0, 32'h08, d);
    wr(OFS_PACC_CTRL, 32'h0C);
    wr(OFS_PORT_A, 32'h08);
    repeat (4) @(posedge pclk);
    rd(OFS_FLAG_ONE, 32'h08, 32'h08, d);
    check("line3_oe_set", pa_oe[3], 1);
    wr(OFS_MASK_TWO, 32'h80);
    // Count writes keep coming; the wrap must still arrive on time
    do begin
      wr(OFS_COUNT, 32'h0);
      rd(OFS_FLAG_TWO, 0, 0, d);
    end while (d[7] !== 1'b1 && cyc < 67500);
    check("ovf_flag", d[7], 1);
    check("ovf_early", cyc >= 65536, 1);
    repeat (2) @(posedge pclk);
    check("ovf_irq", irq_vec[8], 1);
    complete_run();
  end
endmodule : testbench
